//--- verilog/fdtm_params.svh
// Constants for the fast-detect threshold monitor: offsets, fields, resets.
`ifndef FDTM_PARAMS_SVH
`define FDTM_PARAMS_SVH

// Register offsets.
`define FDTM_OFF_CTRL   12'h245
`define FDTM_OFF_UPP_LO 12'h247
`define FDTM_OFF_UPP_HI 12'h248
`define FDTM_OFF_LOW_LO 12'h249
`define FDTM_OFF_LOW_HI 12'h24A
`define FDTM_OFF_DWL_LO 12'h24B
`define FDTM_OFF_DWL_HI 12'h24C
`define FDTM_OFF_SYNC   12'h26F
`define FDTM_OFF_PER_0  12'h271
`define FDTM_OFF_PER_1  12'h272
`define FDTM_OFF_PER_2  12'h273

// Field positions.
`define FDTM_BIT_FD_EN     0
`define FDTM_BIT_FORCE_VAL 2
`define FDTM_BIT_FORCE_EN  3
`define FDTM_BIT_SYNC_EN   0
`define FDTM_BIT_SYNC_MODE 1

// Writable-bit masks; reserved bits read as zero.
`define FDTM_MASK_CTRL   8'h0D
`define FDTM_MASK_THR_HI 8'h1F
`define FDTM_MASK_SYNC   8'h03
`define FDTM_MASK_PER_0  8'hFE

// Reset values.
`define FDTM_RST_BYTE   8'h00
`define FDTM_RST_PERIOD 24'h000080

`endif

//--- verilog/fdtm_pkg.sv
// Types shared by the fast-detect threshold monitor files.
package fdtm_pkg;
  typedef logic [12:0] fdtm_mag_t;
  typedef logic [7:0]  fdtm_byte_t;
  typedef logic [11:0] fdtm_addr_t;
  typedef logic [1:0]  fdtm_sel_t;
endpackage : fdtm_pkg

//--- verilog/fdtm_detect.sv
// One channel of threshold detection with dwell release and forced level.
`timescale 1ns/1ps
`include "fdtm_params.svh"
module fdtm_detect #(
  parameter int MAG_W   = 13,
  parameter int DWELL_W = 16
) (
  input  wire logic               core_clk_i,
  input  wire logic               rst_n_i,
  input  wire logic               fd_en_i,
  input  wire logic               force_en_i,
  input  wire logic               force_val_i,
  input  wire logic [MAG_W-1:0]   upper_i,
  input  wire logic [MAG_W-1:0]   lower_i,
  input  wire logic [DWELL_W-1:0] dwell_i,
  input  wire logic [MAG_W-1:0]   mag_i,
  output logic                    pin_o
);
  import fdtm_pkg::*;

  logic               flag_reg;
  logic               flag_next;
  logic [DWELL_W-1:0] cnt_reg;
  logic [DWELL_W-1:0] cnt_next;

  // Detection flag and dwell counter next state.
  always_comb begin
    flag_next = flag_reg;
    cnt_next  = cnt_reg;
    if (!fd_en_i) begin
      flag_next = 1'b0;
      cnt_next  = dwell_i;
    end else begin
      if (mag_i > upper_i) begin
        flag_next = 1'b1;
      end
      if (mag_i >= lower_i) begin
        cnt_next = dwell_i;
      end else if (cnt_reg == '0) begin
        flag_next = (mag_i > upper_i);
      end else begin
        cnt_next = cnt_reg - 1'b1;
      end
    end
  end

  // Flag, counter and the registered pin, with the override taking priority.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_reg <= 1'b0;
      cnt_reg  <= '0;
      pin_o    <= 1'b0;
    end else begin
      flag_reg <= flag_next;
      cnt_reg  <= cnt_next;
      pin_o    <= force_en_i ? force_val_i : flag_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_force_level: assert property (force_en_i |=> pin_o == $past(force_val_i))
    else $error("Forced pin level wrong.");
  a_normal_follow: assert property (!force_en_i |=> pin_o == flag_reg)
    else $error("Pin does not follow detection.");
  a_disabled_low: assert property ((!fd_en_i && !force_en_i) |=> !pin_o)
    else $error("Pin high while detection disabled.");
  a_upper_sets: assert property ((fd_en_i && !force_en_i && mag_i > upper_i) |=> pin_o)
    else $error("Pin not set above upper threshold.");
  a_dwell_release: assert property ($fell(flag_reg) |-> $past(cnt_reg) == '0 || !$past(fd_en_i))
    else $error("Flag released before dwell elapsed.");
  a_dwell_reload: assert property ((fd_en_i && mag_i >= lower_i) |=> cnt_reg == $past(dwell_i))
    else $error("Dwell counter not reloaded.");

  c_release: cover property (fd_en_i && !force_en_i ##1 $fell(flag_reg));
  c_forced: cover property (force_en_i && force_val_i ##1 pin_o);
endmodule : fdtm_detect

//--- verilog/fdtm_top.sv
// Fast-detect threshold monitor for two channels with signal-monitor sync control.
`timescale 1ns/1ps
`include "fdtm_params.svh"
module fdtm_top #(
  parameter int PERIOD_W = 24
) (
  input  wire logic               core_clk_i,
  input  wire logic               rst_n_i,
  input  wire fdtm_pkg::fdtm_mag_t  sample_mag_a_i,
  input  wire fdtm_pkg::fdtm_mag_t  sample_mag_b_i,
  input  wire logic               sysref_i,
  input  wire logic               sysref_en_i,
  input  wire fdtm_pkg::fdtm_addr_t reg_addr_i,
  input  wire fdtm_pkg::fdtm_sel_t  reg_chan_sel_i,
  input  wire logic               reg_wr_en_i,
  input  wire logic               reg_rd_en_i,
  input  wire fdtm_pkg::fdtm_byte_t reg_wdata_i,
  output fdtm_pkg::fdtm_byte_t      reg_rdata_o,
  output logic                    threshold_flag_out_a_o,
  output logic                    threshold_flag_out_b_o,
  output logic                    monitor_sync_o,
  output logic                    monitor_period_end_o
);
  import fdtm_pkg::*;

  localparam int NUM_CH = 2;

  // Joins a high byte holding five bits with a low byte into a threshold.
  function automatic fdtm_mag_t fdtm_join_thr(input fdtm_byte_t hi, input fdtm_byte_t lo);
    fdtm_join_thr = {hi[4:0], lo};
  endfunction : fdtm_join_thr

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel register storage.
  fdtm_byte_t ctrl_reg    [NUM_CH];
  fdtm_byte_t upp_lo_reg  [NUM_CH];
  fdtm_byte_t upp_hi_reg  [NUM_CH];
  fdtm_byte_t low_lo_reg  [NUM_CH];
  fdtm_byte_t low_hi_reg  [NUM_CH];
  fdtm_byte_t dwl_lo_reg  [NUM_CH];
  fdtm_byte_t dwl_hi_reg  [NUM_CH];
  fdtm_mag_t  mag_w       [NUM_CH];
  logic       pin_w       [NUM_CH];

  // Shared signal-monitor registers and state.
  fdtm_byte_t            sync_ctrl_reg;
  logic [PERIOD_W-1:0]   period_reg;
  logic [PERIOD_W-1:0]   period_cnt_reg;
  logic                  sysref_d_reg;
  logic                  sysref_edge;
  logic                  sync_fire;
  logic                  sync_wr;
  fdtm_byte_t            rdata_next;
  int unsigned           rd_ch;

  assign mag_w[0] = sample_mag_a_i;
  assign mag_w[1] = sample_mag_b_i;

  ////////////////////////////////////////////////////////////////////////////
  // Channel register writes; each channel selected in the mask takes the write.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int c = 0; c < NUM_CH; c++) begin
        ctrl_reg[c]   <= `FDTM_RST_BYTE;
        upp_lo_reg[c] <= `FDTM_RST_BYTE;
        upp_hi_reg[c] <= `FDTM_RST_BYTE;
        low_lo_reg[c] <= `FDTM_RST_BYTE;
        low_hi_reg[c] <= `FDTM_RST_BYTE;
        dwl_lo_reg[c] <= `FDTM_RST_BYTE;
        dwl_hi_reg[c] <= `FDTM_RST_BYTE;
      end
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (reg_wr_en_i && reg_chan_sel_i[c]) begin
          case (reg_addr_i)
            `FDTM_OFF_CTRL:   ctrl_reg[c]   <= reg_wdata_i & `FDTM_MASK_CTRL;
            `FDTM_OFF_UPP_LO: upp_lo_reg[c] <= reg_wdata_i;
            `FDTM_OFF_UPP_HI: upp_hi_reg[c] <= reg_wdata_i & `FDTM_MASK_THR_HI;
            `FDTM_OFF_LOW_LO: low_lo_reg[c] <= reg_wdata_i;
            `FDTM_OFF_LOW_HI: low_hi_reg[c] <= reg_wdata_i & `FDTM_MASK_THR_HI;
            `FDTM_OFF_DWL_LO: dwl_lo_reg[c] <= reg_wdata_i;
            `FDTM_OFF_DWL_HI: dwl_hi_reg[c] <= reg_wdata_i;
            default: ;
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One detector per channel, fed from that channel's registers.
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    fdtm_detect #(
      .MAG_W   (13),
      .DWELL_W (16)
    ) u_detect (
      .core_clk_i  (core_clk_i),
      .rst_n_i     (rst_n_i),
      .fd_en_i     (ctrl_reg[g][`FDTM_BIT_FD_EN]),
      .force_en_i  (ctrl_reg[g][`FDTM_BIT_FORCE_EN]),
      .force_val_i (ctrl_reg[g][`FDTM_BIT_FORCE_VAL]),
      .upper_i     (fdtm_join_thr(upp_hi_reg[g], upp_lo_reg[g])),
      .lower_i     (fdtm_join_thr(low_hi_reg[g], low_lo_reg[g])),
      .dwell_i     ({dwl_hi_reg[g], dwl_lo_reg[g]}),
      .mag_i       (mag_w[g]),
      .pin_o       (pin_w[g])
    );
  end

  // The pins come straight from the detector output flip-flops.
  assign threshold_flag_out_a_o = pin_w[0];
  assign threshold_flag_out_b_o = pin_w[1];

  ////////////////////////////////////////////////////////////////////////////
  // A valid SYSREF edge is a rising edge while the SYSREF input is enabled.
  assign sysref_edge = sysref_i && !sysref_d_reg && sysref_en_i;
  assign sync_fire   = sync_ctrl_reg[`FDTM_BIT_SYNC_EN] && sysref_edge;
  assign sync_wr     = reg_wr_en_i && (reg_addr_i == `FDTM_OFF_SYNC);

  // SYSREF history for edge detection.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sysref_d_reg <= 1'b0;
    end else begin
      sysref_d_reg <= sysref_i;
    end
  end

  // Sync control; a software write in the same cycle beats the self-clear.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_ctrl_reg <= `FDTM_RST_BYTE;
    end else if (sync_wr) begin
      sync_ctrl_reg <= reg_wdata_i & `FDTM_MASK_SYNC;
    end else if (sync_fire && sync_ctrl_reg[`FDTM_BIT_SYNC_MODE]) begin
      sync_ctrl_reg[`FDTM_BIT_SYNC_EN] <= 1'b0;
    end
  end

  // Monitor period; the lowest bit is held at zero so only even periods exist.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      period_reg <= PERIOD_W'(`FDTM_RST_PERIOD);
    end else if (reg_wr_en_i) begin
      case (reg_addr_i)
        `FDTM_OFF_PER_0: period_reg[7:0]   <= reg_wdata_i & `FDTM_MASK_PER_0;
        `FDTM_OFF_PER_1: period_reg[15:8]  <= reg_wdata_i;
        `FDTM_OFF_PER_2: period_reg[23:16] <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // Period counter; a sync event realigns it, otherwise it wraps each period.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      period_cnt_reg       <= '0;
      monitor_period_end_o <= 1'b0;
    end else if (sync_fire) begin
      period_cnt_reg       <= period_reg - 1'b1;
      monitor_period_end_o <= 1'b0;
    end else if (period_cnt_reg == '0) begin
      period_cnt_reg       <= period_reg - 1'b1;
      monitor_period_end_o <= 1'b1;
    end else begin
      period_cnt_reg       <= period_cnt_reg - 1'b1;
      monitor_period_end_o <= 1'b0;
    end
  end

  // One-cycle alignment pulse toward the signal monitor.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      monitor_sync_o <= 1'b0;
    end else begin
      monitor_sync_o <= sync_fire;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path: bit 0 of the select picks channel A, else channel B.
  always_comb begin
    rd_ch      = reg_chan_sel_i[0] ? 0 : 1;
    rdata_next = 8'h00;
    case (reg_addr_i)
      `FDTM_OFF_CTRL:   rdata_next = ctrl_reg[rd_ch];
      `FDTM_OFF_UPP_LO: rdata_next = upp_lo_reg[rd_ch];
      `FDTM_OFF_UPP_HI: rdata_next = upp_hi_reg[rd_ch];
      `FDTM_OFF_LOW_LO: rdata_next = low_lo_reg[rd_ch];
      `FDTM_OFF_LOW_HI: rdata_next = low_hi_reg[rd_ch];
      `FDTM_OFF_DWL_LO: rdata_next = dwl_lo_reg[rd_ch];
      `FDTM_OFF_DWL_HI: rdata_next = dwl_hi_reg[rd_ch];
      `FDTM_OFF_SYNC:   rdata_next = sync_ctrl_reg;
      `FDTM_OFF_PER_0:  rdata_next = period_reg[7:0];
      `FDTM_OFF_PER_1:  rdata_next = period_reg[15:8];
      `FDTM_OFF_PER_2:  rdata_next = period_reg[23:16];
      default:          rdata_next = 8'h00;
    endcase
  end

  // Read data is registered and held until the next read.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_en_i) begin
      reg_rdata_o <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_sync_oneshot: assert property ((sync_fire && sync_ctrl_reg[1] && !sync_wr) |=> !sync_ctrl_reg[0])
    else $error("One-shot sync did not clear enable.");
  a_sync_ignore: assert property ((!sync_ctrl_reg[0] && !sync_wr) |=> !sync_ctrl_reg[0] ##1 !monitor_sync_o)
    else $error("Sync fired after enable cleared.");
  a_sync_continuous: assert property ((sync_fire && !sync_ctrl_reg[1] && !sync_wr) |=> sync_ctrl_reg[0])
    else $error("Continuous sync lost its enable.");
  a_sync_pulse: assert property (sync_fire |=> monitor_sync_o ##1 !monitor_sync_o)
    else $error("Sync pulse missing or too long.");
  a_sync_gated: assert property ((!sysref_en_i || !sync_ctrl_reg[0]) |=> !monitor_sync_o)
    else $error("Sync without SYSREF or enable.");
  a_period_even: assert property (period_reg[0] == 1'b0)
    else $error("Odd monitor period stored.");
  a_period_align: assert property (sync_fire |=> period_cnt_reg == $past(period_reg) - 1'b1)
    else $error("Period counter not realigned.");
  a_thr_hi_rd: assert property ((reg_rd_en_i && reg_addr_i == `FDTM_OFF_UPP_HI) |=> reg_rdata_o[7:5] == 3'b000)
    else $error("Upper threshold high byte too wide.");
  a_low_hi_rd: assert property ((reg_rd_en_i && reg_addr_i == `FDTM_OFF_LOW_HI) |=> reg_rdata_o[7:5] == 3'b000)
    else $error("Lower threshold high byte too wide.");

  // Register port: masked writes land per channel and reads return what is stored.
  a_ctrl_wr_a: assert property ((reg_wr_en_i && reg_chan_sel_i[0] && reg_addr_i == `FDTM_OFF_CTRL)
    |=> ctrl_reg[0] == ($past(reg_wdata_i) & `FDTM_MASK_CTRL))
    else $error("Channel A control write lost.");
  a_ctrl_wr_b: assert property ((reg_wr_en_i && reg_chan_sel_i[1] && reg_addr_i == `FDTM_OFF_CTRL)
    |=> ctrl_reg[1] == ($past(reg_wdata_i) & `FDTM_MASK_CTRL))
    else $error("Channel B control write lost.");
  a_ctrl_hold_a: assert property (!(reg_wr_en_i && reg_chan_sel_i[0] && reg_addr_i == `FDTM_OFF_CTRL)
    |=> $stable(ctrl_reg[0]))
    else $error("Channel A control changed without a write.");
  a_sync_wr_wins: assert property (sync_wr
    |=> sync_ctrl_reg == ($past(reg_wdata_i) & `FDTM_MASK_SYNC))
    else $error("Sync control write lost.");
  a_rd_sync: assert property ((reg_rd_en_i && reg_addr_i == `FDTM_OFF_SYNC)
    |=> reg_rdata_o == $past(sync_ctrl_reg))
    else $error("Sync control read wrong.");
  a_rd_dwell_lo: assert property ((reg_rd_en_i && reg_chan_sel_i[0] && reg_addr_i == `FDTM_OFF_DWL_LO)
    |=> reg_rdata_o == $past(dwl_lo_reg[0]))
    else $error("Dwell low byte read wrong.");
  a_rd_dwell_hi: assert property ((reg_rd_en_i && reg_chan_sel_i[0] && reg_addr_i == `FDTM_OFF_DWL_HI)
    |=> reg_rdata_o == $past(dwl_hi_reg[0]))
    else $error("Dwell high byte read wrong.");
  a_rd_period: assert property ((reg_rd_en_i && reg_addr_i == `FDTM_OFF_PER_0)
    |=> reg_rdata_o == $past(period_reg[7:0]))
    else $error("Period low byte read wrong.");

  // Pins seen from the channel control registers: override first, then enable.
  a_force_a_set: assert property ((ctrl_reg[0][`FDTM_BIT_FORCE_EN] && ctrl_reg[0][`FDTM_BIT_FORCE_VAL])
    |=> threshold_flag_out_a_o)
    else $error("Pin A not forced high.");
  a_force_a_clr: assert property ((ctrl_reg[0][`FDTM_BIT_FORCE_EN] && !ctrl_reg[0][`FDTM_BIT_FORCE_VAL])
    |=> !threshold_flag_out_a_o)
    else $error("Pin A not forced low.");
  a_force_b_set: assert property ((ctrl_reg[1][`FDTM_BIT_FORCE_EN] && ctrl_reg[1][`FDTM_BIT_FORCE_VAL])
    |=> threshold_flag_out_b_o)
    else $error("Pin B not forced high.");
  a_off_a_low: assert property ((ctrl_reg[0] == `FDTM_RST_BYTE) |=> !threshold_flag_out_a_o)
    else $error("Pin A high while channel A is off.");
  a_off_b_low: assert property ((ctrl_reg[1] == `FDTM_RST_BYTE) |=> !threshold_flag_out_b_o)
    else $error("Pin B high while channel B is off.");
  a_upper_a: assert property ((ctrl_reg[0] == 8'h01
    && sample_mag_a_i > fdtm_join_thr(upp_hi_reg[0], upp_lo_reg[0])) |=> threshold_flag_out_a_o)
    else $error("Pin A not set above its upper threshold.");

  // Period counter wrap with an end pulse and plain count-down; then the source of a sync pulse.
  a_period_wrap: assert property ((period_cnt_reg == '0 && !sync_fire)
    |=> monitor_period_end_o && period_cnt_reg == $past(period_reg) - 1'b1)
    else $error("Period counter did not wrap.");
  a_period_count: assert property ((period_cnt_reg != '0 && !sync_fire)
    |=> !monitor_period_end_o && period_cnt_reg == $past(period_cnt_reg) - 1'b1)
    else $error("Period counter did not count down.");
  a_sync_source: assert property (monitor_sync_o
    |-> $past(sysref_i) && !$past(sysref_d_reg) && $past(sysref_en_i) && $past(sync_ctrl_reg[0]))
    else $error("Sync pulse without an enabled SYSREF edge.");

  c_oneshot: cover property (sync_fire && sync_ctrl_reg[1] ##1 !sync_ctrl_reg[0]);
  c_cont_twice: cover property (sync_fire && !sync_ctrl_reg[1] ##[2:50] sync_fire);
  c_pin_a: cover property ($rose(threshold_flag_out_a_o));
endmodule : fdtm_top

//--- sim/fdtm_agc_model.sv
// Downstream gain-control sampler that counts attack events on both fast-detect pins.
`timescale 1ns/1ps
module fdtm_agc_model (
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  input  wire logic flag_a_i,
  input  wire logic flag_b_i,
  output int        rises_a_o,
  output int        rises_b_o
);
  logic prev_a_reg;
  logic prev_b_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Each low-to-high step of a pin is one attack request; levels are only sampled.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_a_reg <= 1'b0;
      prev_b_reg <= 1'b0;
      rises_a_o  <= 0;
      rises_b_o  <= 0;
    end else begin
      prev_a_reg <= flag_a_i;
      prev_b_reg <= flag_b_i;
      if (flag_a_i === 1'b1 && prev_a_reg === 1'b0) rises_a_o <= rises_a_o + 1;
      if (flag_b_i === 1'b1 && prev_b_reg === 1'b0) rises_b_o <= rises_b_o + 1;
    end
  end
endmodule : fdtm_agc_model

//--- sim/fdtm_tb_top.sv
// Self-checking bench for the fast-detect threshold monitor.
`timescale 1ns/1ps
`include "fdtm_params.svh"
`define CHK(act, exp) begin checked++; if ((act) !== (exp)) begin fails++; \
  $display("ERROR %0t: value %0h, expected %0h", $time, (act), (exp)); end end
module fdtm_tb_top;
  import fdtm_pkg::*;
  logic       core_clk_i;
  logic       rst_n_i;
  fdtm_mag_t  sample_mag_a_i;
  fdtm_mag_t  sample_mag_b_i;
  logic       sysref_i;
  logic       sysref_en_i;
  fdtm_addr_t reg_addr_i;
  fdtm_sel_t  reg_chan_sel_i;
  logic       reg_wr_en_i;
  logic       reg_rd_en_i;
  fdtm_byte_t reg_wdata_i;
  fdtm_byte_t reg_rdata_o;
  logic       threshold_flag_out_a_o;
  logic       threshold_flag_out_b_o;
  logic       monitor_sync_o;
  logic       monitor_period_end_o;
  int         rises_a;
  int         rises_b;
  int         fails = 0;
  int         checked = 0;
  int         cycles = 0;
  int         sync_cnt = 0;
  int         n;
  int         s0;
  fdtm_byte_t d;
  // Register map walk: address, reset value, write value, value read back.
  fdtm_addr_t tbl_addr [10] = '{`FDTM_OFF_CTRL, `FDTM_OFF_UPP_LO, `FDTM_OFF_UPP_HI, `FDTM_OFF_LOW_LO,
    `FDTM_OFF_LOW_HI, `FDTM_OFF_DWL_LO, `FDTM_OFF_DWL_HI, `FDTM_OFF_SYNC, `FDTM_OFF_PER_0, 12'h246};
  fdtm_byte_t tbl_rst [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00};
  fdtm_byte_t tbl_wval [10] = '{8'hFF, 8'hFF, 8'hFF, 8'hA5, 8'hFF, 8'h5A, 8'hC3, 8'hFC, 8'hFF, 8'hFF};
  fdtm_byte_t tbl_wexp [10] = '{8'h0D, 8'hFF, 8'h1F, 8'hA5, 8'h1F, 8'h5A, 8'hC3, 8'h00, 8'hFE, 8'h00};

  fdtm_top u_fdtm_top (
    .core_clk_i             (core_clk_i),
    .rst_n_i                (rst_n_i),
    .sample_mag_a_i         (sample_mag_a_i),
    .sample_mag_b_i         (sample_mag_b_i),
    .sysref_i               (sysref_i),
    .sysref_en_i            (sysref_en_i),
    .reg_addr_i             (reg_addr_i),
    .reg_chan_sel_i         (reg_chan_sel_i),
    .reg_wr_en_i            (reg_wr_en_i),
    .reg_rd_en_i            (reg_rd_en_i),
    .reg_wdata_i            (reg_wdata_i),
    .reg_rdata_o            (reg_rdata_o),
    .threshold_flag_out_a_o (threshold_flag_out_a_o),
    .threshold_flag_out_b_o (threshold_flag_out_b_o),
    .monitor_sync_o         (monitor_sync_o),
    .monitor_period_end_o   (monitor_period_end_o)
  );

  fdtm_agc_model u_fdtm_agc_model (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .flag_a_i   (threshold_flag_out_a_o),
    .flag_b_i   (threshold_flag_out_b_o),
    .rises_a_o  (rises_a),
    .rises_b_o  (rises_b)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // The clock runs at 50 MHz.
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end

  // Counts sync pulses and cuts a hung run short.
  always @(posedge core_clk_i) begin
    cycles++;
    if (monitor_sync_o === 1'b1) sync_cnt++;
    if (cycles == 20000) begin
      fails++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One-cycle register strobes launched and dropped on falling edges.
  task automatic wr(input fdtm_addr_t a, input fdtm_sel_t s, input fdtm_byte_t v);
    @(negedge core_clk_i);
    reg_addr_i = a;
    reg_chan_sel_i = s;
    reg_wdata_i = v;
    reg_wr_en_i = 1'b1;
    @(negedge core_clk_i);
    reg_wr_en_i = 1'b0;
  endtask : wr

  task automatic rd(input fdtm_addr_t a, input fdtm_sel_t s, output fdtm_byte_t v);
    @(negedge core_clk_i);
    reg_addr_i = a;
    reg_chan_sel_i = s;
    reg_rd_en_i = 1'b1;
    @(negedge core_clk_i);
    reg_rd_en_i = 1'b0;
    v = reg_rdata_o;
  endtask : rd

  // Drops one channel below its lower threshold and counts cycles until the pin clears.
  task automatic release_time(input bit on_b, output int cnt);
    @(negedge core_clk_i);
    if (on_b) sample_mag_b_i = 13'h0000;
    else sample_mag_a_i = 13'h000A;
    cnt = 0;
    do begin
      @(negedge core_clk_i);
      cnt++;
    end while ((on_b ? threshold_flag_out_b_o : threshold_flag_out_a_o) !== 1'b0 && cnt < 2000);
  endtask : release_time

  // Edges nine cycles apart when called back to back: four cycles high, then five low.
  task automatic sysref_pulse();
    @(negedge core_clk_i);
    sysref_i = 1'b1;
    repeat (4) @(negedge core_clk_i);
    sysref_i = 1'b0;
    repeat (4) @(negedge core_clk_i);
  endtask : sysref_pulse

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: register map, forced level, detection, dwell, sync.
  initial begin
    rst_n_i = 1'b0;
    sample_mag_a_i = 13'h0000;
    sample_mag_b_i = 13'h0000;
    {sysref_i, sysref_en_i, reg_wr_en_i, reg_rd_en_i} = 4'h0;
    reg_addr_i = 12'h000;
    reg_chan_sel_i = 2'h1;
    reg_wdata_i = 8'h00;
    repeat (8) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    for (int i = 0; i < 10; i++) begin
      rd(tbl_addr[i], 2'h1, d);
      `CHK(d, tbl_rst[i])
      wr(tbl_addr[i], 2'h3, tbl_wval[i]);
      rd(tbl_addr[i], 2'h1, d);
      `CHK(d, tbl_wexp[i])
    end
    // A reset in mid-run returns the map to its reset values.
    rst_n_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    rd(`FDTM_OFF_CTRL, 2'h1, d);
    `CHK(d, 8'h00)
    wr(`FDTM_OFF_CTRL, 2'h1, 8'h0C);
    @(negedge core_clk_i);
    `CHK(threshold_flag_out_a_o, 1'b1)
    `CHK(threshold_flag_out_b_o, 1'b0)
    wr(`FDTM_OFF_CTRL, 2'h1, 8'h08);
    @(negedge core_clk_i);
    `CHK(threshold_flag_out_a_o, 1'b0)
    // Channel A: upper 0x1064, lower 0x0032, dwell 0x0103.
    wr(`FDTM_OFF_UPP_LO, 2'h1, 8'h64);
    wr(`FDTM_OFF_UPP_HI, 2'h1, 8'h10);
    wr(`FDTM_OFF_LOW_LO, 2'h1, 8'h32);
    wr(`FDTM_OFF_DWL_LO, 2'h1, 8'h03);
    wr(`FDTM_OFF_DWL_HI, 2'h1, 8'h01);
    wr(`FDTM_OFF_CTRL, 2'h1, 8'h00);
    sample_mag_a_i = 13'h1FFF;
    repeat (3) @(negedge core_clk_i);
    `CHK(threshold_flag_out_a_o, 1'b0)
    wr(`FDTM_OFF_CTRL, 2'h1, 8'h09);
    repeat (2) @(negedge core_clk_i);
    `CHK(threshold_flag_out_a_o, 1'b0)
    // Disabling drops the flag latched while forced, so the equal case starts clean.
    wr(`FDTM_OFF_CTRL, 2'h1, 8'h08);
    sample_mag_a_i = 13'h1064;
    wr(`FDTM_OFF_CTRL, 2'h1, 8'h01);
    repeat (3) @(negedge core_clk_i);
    `CHK(threshold_flag_out_a_o, 1'b0)
    sample_mag_a_i = 13'h1065;
    @(negedge core_clk_i);
    `CHK(threshold_flag_out_a_o, 1'b1)
    // Five cycles below, then one at the lower threshold, which reloads the count.
    sample_mag_a_i = 13'h000A;
    repeat (5) @(negedge core_clk_i);
    `CHK(threshold_flag_out_a_o, 1'b1)
    sample_mag_a_i = 13'h0032;
    @(negedge core_clk_i);
    `CHK(threshold_flag_out_a_o, 1'b1)
    release_time(1'b0, n);
    `CHK(n, 16'h0104)
    `CHK(rises_a, 2)
    // Channel B alone: upper 5, lower 3, dwell 0 clears on the first low cycle.
    wr(`FDTM_OFF_UPP_LO, 2'h2, 8'h05);
    wr(`FDTM_OFF_LOW_LO, 2'h2, 8'h03);
    wr(`FDTM_OFF_CTRL, 2'h2, 8'h01);
    rd(`FDTM_OFF_UPP_LO, 2'h1, d);
    `CHK(d, 8'h64)
    sample_mag_b_i = 13'h0006;
    repeat (2) @(negedge core_clk_i);
    `CHK(threshold_flag_out_b_o, 1'b1)
    release_time(1'b1, n);
    `CHK(n, 1)
    `CHK(rises_b, 1)
    // Monitor period of four cycles, then both sync modes.
    wr(`FDTM_OFF_PER_0, 2'h3, 8'h04);
    n = 0;
    while (monitor_period_end_o !== 1'b1 && n < 300) begin
      @(negedge core_clk_i);
      n++;
    end
    n = 0;
    do begin
      @(negedge core_clk_i);
      n++;
    end while (monitor_period_end_o !== 1'b1 && n < 300);
    `CHK(n, 4)
    sysref_en_i = 1'b1;
    wr(`FDTM_OFF_SYNC, 2'h3, 8'h01);
    s0 = sync_cnt;
    sysref_pulse();
    sysref_pulse();
    `CHK(sync_cnt - s0, 2)
    sysref_en_i = 1'b0;
    sysref_pulse();
    `CHK(sync_cnt - s0, 2)
    sysref_en_i = 1'b1;
    wr(`FDTM_OFF_SYNC, 2'h3, 8'h03);
    sysref_pulse();
    `CHK(sync_cnt - s0, 3)
    rd(`FDTM_OFF_SYNC, 2'h3, d);
    `CHK(d, 8'h02)
    sysref_pulse();
    `CHK(sync_cnt - s0, 3)
    print_verdict();
  end
endmodule : fdtm_tb_top
